// ===== bit_oriented_instruction_exec.sv
/*
 Executes the clear-bit, set-bit and test-bit-skip-if-clear instructions.
 A taken skip throws away the word latched as the test ends and idles one whole cycle.
 Assumes the fetch unit holds insn stable for a whole instruction cycle and
 that the register file returns read data in the same clock as a read strobe, before the edge that ends it.
*/
`timescale 1ns/1ps
`default_nettype none
module bit_oriented_instruction_exec #(
   parameter int DATA_W = bit_exec_pkg::DATA_W
) (
   input  wire logic                               clk,
   input  wire logic                               rstn,
   input  wire logic [bit_exec_pkg::INSN_W-1:0]    insn,
   input  wire logic                               insnValid,
   input  wire logic [DATA_W-1:0]                  fileRdata,
   output bit_exec_pkg::file_req_t                 fileReq,
   output logic                                    skipNext,
   output logic                                    nopCycle,
   output logic [1:0]                              quarterOut,
   output logic                                    busy
);
   // The masks and the byte path are written for eight bits; refuse anything else
   if (DATA_W != 8) begin : g_width_check
      $error("DATA_W must be 8");
   end

   typedef enum {S_EXEC, S_SKIP} state_t;

   logic [1:0] quarter;
   logic       lastQuarter;
   // Quarter phase source shared by the latch, the strobes and the skip logic
   quarter_counter u_quarter (
      .clk         (clk),
      .rstn        (rstn),
      .quarter     (quarter),
      .lastQuarter (lastQuarter)
   );

   // Decode fields; the shifts stay fixed by the package positions
   function automatic bit_exec_pkg::bit_op_t decodeOp(input logic [bit_exec_pkg::INSN_W-1:0] w);
      logic [3:0] opc;
      opc = w[bit_exec_pkg::OPC_LSB +: 4];
      if (opc == bit_exec_pkg::OPC_CLEAR)     decodeOp = bit_exec_pkg::OP_CLEAR;
      else if (opc == bit_exec_pkg::OPC_SET)  decodeOp = bit_exec_pkg::OP_SET;
      else if (opc == bit_exec_pkg::OPC_TEST) decodeOp = bit_exec_pkg::OP_TEST;
      else                                    decodeOp = bit_exec_pkg::OP_NONE;
   endfunction : decodeOp

   bit_exec_pkg::bit_op_t op_ff;
   bit_exec_pkg::bit_op_t nxt_op;
   logic [2:0]  bitPos_ff;
   logic [6:0]  addr_ff;
   logic [7:0]  data_ff;
   state_t      state_ff;
   state_t      nxt_state;
   bit_exec_pkg::file_req_t req_ff;
   bit_exec_pkg::file_req_t nxt_req;
   logic        skip_ff;
   logic        nop_ff;
   logic [1:0]  qOut_ff;
   logic        busy_ff;

   // Operand fields: bit position 9..7, address 6..0; no flag is produced
   wire [2:0] insnBit  = insn[bit_exec_pkg::BIT_LSB +: bit_exec_pkg::BIT_W];
   wire [6:0] insnAddr = insn[bit_exec_pkg::ADDR_LSB +: bit_exec_pkg::ADDR_W];
   wire       inSkip   = (state_ff == S_SKIP);

   // Modify step: one-hot mask over the read byte
   wire [7:0] bitMask  = 8'h01 << bitPos_ff;
   wire [7:0] clrValue = data_ff & ~bitMask;
   wire [7:0] setValue = data_ff | bitMask;
   wire [7:0] modValue = (op_ff == bit_exec_pkg::OP_SET) ? setValue : clrValue;
   wire       testBit  = data_ff[bitPos_ff];
   wire       isRmw    = (op_ff == bit_exec_pkg::OP_SET) || (op_ff == bit_exec_pkg::OP_CLEAR);
   wire       skipTaken = (op_ff == bit_exec_pkg::OP_TEST) && !testBit;
   wire       dropNext  = lastQuarter && skipTaken && !inSkip;

   // Next word to execute; the one fetched while a test decides to skip is thrown away,
   // while the word fetched during the skip cycle itself runs normally afterwards
   assign nxt_op = (insnValid && !dropNext) ? decodeOp(insn) : bit_exec_pkg::OP_NONE;

   // Register file strobes per quarter: read in Q2, write in Q4
   always_comb begin
      nxt_req       = '0;
      nxt_req.addr  = addr_ff;
      nxt_req.wdata = modValue;
      if (quarter == 2'h0 && op_ff != bit_exec_pkg::OP_NONE) begin
         nxt_req.rd = 1'b1;
      end
      if (quarter == 2'h2 && isRmw) begin
         nxt_req.wr = 1'b1;
      end
   end

   // Skip state lasts exactly one whole instruction cycle
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         S_EXEC: if (lastQuarter && skipTaken) nxt_state = S_SKIP;
         S_SKIP: if (lastQuarter) nxt_state = S_EXEC;
      endcase
   end

   // Decode latches at Q1; read data captured in Q3 for the process step
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         op_ff     <= bit_exec_pkg::OP_NONE;
         bitPos_ff <= 3'h0;
         addr_ff   <= 7'h00;
      end else if (quarter == 2'h3) begin
         op_ff     <= nxt_op;
         bitPos_ff <= insnBit;
         addr_ff   <= insnAddr;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         data_ff <= bit_exec_pkg::DATA_RST;
      end else if (quarter == 2'h1) begin
         data_ff <= fileRdata;
      end
   end

   // Registered outputs
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_ff <= S_EXEC;
         req_ff   <= '0;
         skip_ff  <= 1'b0;
         nop_ff   <= 1'b0;
         qOut_ff  <= 2'h0;
         busy_ff  <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         req_ff   <= nxt_req;
         skip_ff  <= lastQuarter && skipTaken && !inSkip;
         nop_ff   <= (nxt_state == S_SKIP);
         qOut_ff  <= quarter;
         busy_ff  <= (op_ff != bit_exec_pkg::OP_NONE);
      end
   end

   assign fileReq    = req_ff;
   assign skipNext   = skip_ff;
   assign nopCycle   = nop_ff;
   assign quarterOut = qOut_ff;
   assign busy       = busy_ff;

   // Checks, grouped by the behaviour each one guards

   // A clear must leave the chosen bit at zero in the byte written back
   a_clear_writes_zero: assert property (@(posedge clk) disable iff (!rstn)
      (fileReq.wr && $past(op_ff) == bit_exec_pkg::OP_CLEAR) |-> !fileReq.wdata[$past(bitPos_ff)])
      else $error("clear wrote a one");

   // A set must leave the chosen bit at one
   a_set_writes_one: assert property (@(posedge clk) disable iff (!rstn)
      (fileReq.wr && $past(op_ff) == bit_exec_pkg::OP_SET) |-> fileReq.wdata[$past(bitPos_ff)])
      else $error("set wrote a zero");

   // Every other bit goes back exactly as the register file returned it two clocks earlier
   a_other_bits_kept: assert property (@(posedge clk) disable iff (!rstn)
      fileReq.wr |-> ((fileReq.wdata ^ $past(fileRdata, 2)) & ~(8'h01 << $past(bitPos_ff))) == 8'h00)
      else $error("write changed another bit");

   // An untaken test lets the following word run: no skip pulse
   a_test_no_skip: assert property (@(posedge clk) disable iff (!rstn)
      (lastQuarter && op_ff == bit_exec_pkg::OP_TEST && testBit) |=> !skipNext)
      else $error("skip on set bit");

   // A taken test announces the skip and enters the idle cycle at once
   a_skip_taken: assert property (@(posedge clk) disable iff (!rstn)
      (lastQuarter && skipTaken && !inSkip) |=> skipNext ##0 nopCycle[*4])
      else $error("skip not taken");

   // The idle cycle is exactly one instruction cycle long, so the test costs two in all
   a_skip_one_cycle: assert property (@(posedge clk) disable iff (!rstn)
      skipNext |-> nopCycle[*4] ##1 !nopCycle)
      else $error("skip cycle length wrong");

   // The skip pulse lasts a single clock so the fetch unit drops only one word
   a_skip_pulse_once: assert property (@(posedge clk) disable iff (!rstn)
      skipNext |=> !skipNext)
      else $error("skip pulse too long");

   // The discarded word is never held for execution
   a_discard_quiet: assert property (@(posedge clk) disable iff (!rstn)
      dropNext |=> ##1 (!busy)[*4])
      else $error("discarded word executed");

   // No register access at all in the extra cycle
   a_skip_idle: assert property (@(posedge clk) disable iff (!rstn)
      inSkip |-> ##1 (!fileReq.rd && !fileReq.wr))
      else $error("activity in skip cycle");

   // Set: read in the second quarter, write back two clocks later
   a_set_rmw_order: assert property (@(posedge clk) disable iff (!rstn)
      (quarter == 2'h0 && op_ff == bit_exec_pkg::OP_SET) |=> fileReq.rd ##2 fileReq.wr)
      else $error("set sequence broken");

   // Clear: the write goes to the very register that was read
   a_clear_same_addr: assert property (@(posedge clk) disable iff (!rstn)
      (fileReq.rd && $past(op_ff) == bit_exec_pkg::OP_CLEAR) |->
         ##2 (fileReq.wr && fileReq.addr == $past(fileReq.addr, 2)))
      else $error("clear write address moved");

   // Every write is the second half of a read-modify-write
   a_write_after_read: assert property (@(posedge clk) disable iff (!rstn)
      fileReq.wr |-> $past(fileReq.rd, 2))
      else $error("write without read");

   // A test never writes the register file back
   a_test_never_writes: assert property (@(posedge clk) disable iff (!rstn)
      (op_ff == bit_exec_pkg::OP_TEST) |=> !fileReq.wr)
      else $error("test wrote file");

   // The address presented comes from bits 6..0 of the word latched two clocks before
   a_field_address: assert property (@(posedge clk) disable iff (!rstn)
      fileReq.rd |-> fileReq.addr == $past(insnAddr, 2))
      else $error("address field misplaced");
endmodule : bit_oriented_instruction_exec
`default_nettype wire

// ===== bit_exec_pkg.sv
/*
 Constants and carrier types for the bit-oriented instruction executor.
 Assumes a 14-bit instruction word and a 7-bit file register address space.
*/
// Summary of operation
// - Clear opcode forces the chosen bit of register f to zero, others kept.
// - Set opcode forces the chosen bit of register f to one, others kept.
// - Test-skip-clear continues normally when the tested bit reads one.
// - Tested bit zero: discard the fetched next instruction, run a no-operation.
// - The extra skip cycle does nothing in all four quarters.
// - Set is one cycle: decode, read, modify, write back.
// - Clear reads f in the read quarter, writes f back in write quarter.
`default_nettype none
package bit_exec_pkg;
   localparam int INSN_W    = 14;
   localparam int ADDR_W    = 7;
   localparam int DATA_W    = 8;
   localparam int BIT_W     = 3;
   localparam int BIT_LSB   = 7;
   localparam int ADDR_LSB  = 0;
   localparam int OPC_LSB   = 10;
   localparam int QCOUNT    = 4;
   localparam logic [3:0] OPC_CLEAR = 4'h4;  // 01 00
   localparam logic [3:0] OPC_SET   = 4'h5;  // 01 01
   localparam logic [3:0] OPC_TEST  = 4'h6;  // 01 10
   localparam logic [1:0] Q_RESET   = 2'h0;
   localparam logic [7:0] DATA_RST  = 8'h00;

   typedef enum logic [1:0] {OP_NONE, OP_CLEAR, OP_SET, OP_TEST} bit_op_t;

   // Register file port request as one bundle
   typedef struct packed {
      logic                rd;
      logic                wr;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   wdata;
   } file_req_t;
endpackage : bit_exec_pkg
`default_nettype wire

// ===== quarter_counter.sv
/*
 Quarter phase counter: splits each instruction cycle into four clocks.
 Assumes one clock per quarter; the cycle begins at quarter zero after reset.
*/
`timescale 1ns/1ps
`default_nettype none
module quarter_counter (
   input  wire logic       clk,
   input  wire logic       rstn,
   output logic [1:0]      quarter,
   output logic            lastQuarter
);
   logic [1:0] q_ff;
   logic [1:0] nxt_q;

   // Wraps naturally at four
   assign nxt_q       = q_ff + 2'h1;
   assign quarter     = q_ff;
   assign lastQuarter = (q_ff == 2'h3);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         q_ff <= bit_exec_pkg::Q_RESET;
      end else begin
         q_ff <= nxt_q;
      end
   end
endmodule : quarter_counter
`default_nettype wire

// ===== test_bit_oriented_instruction_exec.sv
/*
 Self-checking bench for the bit instruction executor.
 Assumes the bench plays the register file: an array answers reads and takes writes.
*/
`timescale 1ns/1ps
`default_nettype none
module test_bit_oriented_instruction_exec;
   typedef struct {logic [3:0] op; logic [2:0] b; logic [6:0] a; logic [7:0] pre;} row_t;
   logic                    clk = 1'b0;
   logic                    rstn = 1'b0;
   logic [13:0]             insn = 14'h0000;
   logic                    insnValid = 1'b0;
   logic [7:0]              fileRdata = 8'h00;
   bit_exec_pkg::file_req_t fileReq;
   logic                    skipNext;
   logic                    nopCycle;
   logic                    busy;
   logic [1:0]              quarterOut;
   logic [7:0]              mem [128];
   logic [6:0]              wrAddr;
   logic [7:0]              wrData;
   int                      n_fail = 0, samples_checked = 0, nWr, nRd, nSkip, nNop, nBusy;
   row_t rows [7] = '{'{4'h4, 3'h7, 7'h7f, 8'hc7}, '{4'h5, 3'h7, 7'h00, 8'h0a}, '{4'h5, 3'h0, 7'h2a, 8'hff},
                      '{4'h4, 3'h0, 7'h01, 8'h00}, '{4'h6, 3'h1, 7'h10, 8'h02}, '{4'h6, 3'h7, 7'h7f, 8'h7f},
                      '{4'h7, 3'h2, 7'h05, 8'h00}};

   always #20 clk = ~clk;

   bit_oriented_instruction_exec dut (.clk(clk), .rstn(rstn), .insn(insn), .insnValid(insnValid),
      .fileRdata(fileRdata), .fileReq(fileReq), .skipNext(skipNext), .nopCycle(nopCycle),
      .quarterOut(quarterOut), .busy(busy));

   // Monitor and register file at the falling edge, where registered outputs have settled
   always @(negedge clk) begin
      if (fileReq.wr === 1'b1) begin
         nWr++;
         wrAddr = fileReq.addr;
         wrData = fileReq.wdata;
         mem[fileReq.addr] = fileReq.wdata;
      end
      nRd += (fileReq.rd === 1'b1);
      nSkip += (skipNext === 1'b1);
      nNop += (nopCycle === 1'b1);
      nBusy += (busy === 1'b1);
      fileRdata <= mem[fileReq.addr];  // Follows the address so any read latency sees fresh data
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   // One instruction slot of four clocks holds exactly one capture edge whatever the phase
   task automatic slot(input logic [13:0] w, input logic v);
      insn = w;
      insnValid = v;
      repeat (4) @(negedge clk);
      check("quarter phase", quarterOut, 2'h3);
   endtask : slot

   task automatic idle();
      repeat (3) slot(14'h0000, 1'b0);
   endtask : idle

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : stop_test

   // Watchdog well beyond the few hundred clocks the tests need
   initial begin
      #800_000;
      n_fail++;
      stop_test();
   end

   initial begin
      logic [7:0] exp;
      logic       rmw, tst, skip;
      foreach (mem[i]) mem[i] = 8'h00;
      repeat (8) @(negedge clk);
      check("fileReq in reset", fileReq, 17'h00000);
      check("flags in reset", {skipNext, nopCycle, busy}, 3'h0);
      $display("reset done");
      rstn = 1'b1;
      foreach (rows[i]) begin
         mem[rows[i].a] = rows[i].pre;
         {nWr, nRd, nSkip, nNop, nBusy} = '0;
         rmw = (rows[i].op == bit_exec_pkg::OPC_SET) || (rows[i].op == bit_exec_pkg::OPC_CLEAR);
         tst = (rows[i].op == bit_exec_pkg::OPC_TEST);
         skip = tst && !rows[i].pre[rows[i].b];
         exp = rows[i].pre;
         exp[rows[i].b] = (rows[i].op == bit_exec_pkg::OPC_SET);
         slot({rows[i].op, rows[i].b, rows[i].a}, 1'b1);
         idle();
         check("writes", nWr, rmw);
         check("reads", nRd, rmw | tst);
         if (rmw) check("write address", wrAddr, rows[i].a);
         if (rmw) check("write data", wrData, exp);
         check("skips", nSkip, skip);
         check("nop clocks", nNop, skip ? 4 : 0);
         check("busy clocks", nBusy, (rmw | tst) ? 4 : 0);
         $display("row %0d done", i);
      end
      // Back-to-back set on one register: second read must see the first write
      mem[5] = 8'h00;
      slot(14'h1585, 1'b1);
      slot(14'h1705, 1'b1);
      idle();
      check("chained rmw", mem[5], 8'h48);
      $display("back-to-back done");
      // Taken skip discards the valid set that follows; the word fetched in the skip cycle runs
      mem[9] = 8'h00;
      {nWr, nSkip, nNop} = '0;
      slot(14'h1909, 1'b1);
      slot(14'h1509, 1'b1);
      slot(14'h1489, 1'b1);
      idle();
      check("writes around skip", nWr, 1);
      check("skip pulses", nSkip, 1);
      check("after skip", mem[9], 8'h02);
      check("skip nop clocks", nNop, 4);
      mem[9] = 8'h02;
      slot(14'h1889, 1'b1);
      slot(14'h1409, 1'b1);
      idle();
      check("kept next", mem[9], 8'h03);
      $display("skip sequence done");
      // Reset in mid-instruction clears fileReq, skipNext, nopCycle and busy
      slot(14'h1909, 1'b1);
      rstn = 1'b0;
      @(negedge clk);
      check("fileReq mid reset", fileReq, 17'h00000);
      check("flags mid reset", {skipNext, nopCycle, busy}, 3'h0);
      rstn = 1'b1;
      slot(14'h1509, 1'b1);
      idle();
      check("set after reset", mem[9], 8'h07);
      $display("mid-run reset done");
      stop_test();
   end
endmodule : test_bit_oriented_instruction_exec
`default_nettype wire
